// *** rtl/cdsc_pkg.sv ***
// Shared constants and types for the current converter serial control block
package cdsc_pkg;
  localparam int unsigned WORD_W      = 24;       // Shift word width
  localparam int unsigned ADDR_W      = 8;        // Address byte width
  localparam int unsigned DATA_W      = 16;       // Data word width
  localparam int unsigned ADDR_MSB    = 23;       // Address byte top bit
  localparam int unsigned ADDR_LSB    = 16;       // Address byte low bit
  localparam logic [7:0]  ADDR_NOP    = 8'h00;    // No operation
  localparam logic [7:0]  ADDR_DATA   = 8'h01;    // Data register
  localparam logic [7:0]  ADDR_RDBK   = 8'h02;    // Readback request
  localparam logic [7:0]  ADDR_CTRL   = 8'h55;    // Control register
  localparam logic [7:0]  ADDR_RST    = 8'h56;    // Reset register
  localparam int unsigned RANGE_LSB   = 0;        // Range field low bit in control
  localparam int unsigned DCHAIN_BIT  = 3;        // Daisy-chain enable bit in control
  localparam int unsigned RDSEL_LSB   = 0;        // Readback select field low bit
  localparam logic [1:0]  RDSEL_STAT  = 2'h0;     // Readback of status
  localparam logic [1:0]  RDSEL_DATA  = 2'h1;     // Readback of data register
  localparam logic [1:0]  RDSEL_CTRL  = 2'h2;     // Readback of control register
  localparam logic [2:0]  RANGE_4_20  = 3'h5;     // 4 to 20 mA range code
  localparam logic [2:0]  RANGE_0_20  = 3'h6;     // 0 to 20 mA range code
  localparam logic [2:0]  RANGE_0_24  = 3'h7;     // 0 to 24 mA range code
  localparam logic [15:0] DATA_RST    = 16'h0000; // Data register after reset
  localparam logic [15:0] CTRL_RST    = 16'h0000; // Control register after reset
  localparam logic [15:0] ZERO_CODE   = 16'h0000; // Zero-scale code
  localparam int unsigned SCLK_MAX_MHZ = 30;      // Fastest host shift clock
  localparam int unsigned SYS_MHZ     = 40;       // System clock rate
  localparam int unsigned SYNC_STAGES = 2;        // Synchroniser depth
  typedef enum logic [1:0] {
    CDSC_OUT_IDLE,
    CDSC_OUT_RDBK,
    CDSC_OUT_CHAIN
  } cdsc_out_mode_t;
endpackage

// *** rtl/cdsc_sync.sv ***
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/10ps
`default_nettype none
module cdsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,   // Destination clock
  input  wire logic         reset_in, // Asynchronous reset
  input  wire logic [W-1:0] d_in,     // Asynchronous level
  output var  logic [W-1:0] q_out     // Synchronised level
);
  logic [W-1:0] meta_r; // First stage, read only by second stage

  // Two stages per bit
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** rtl/cdsc_top.sv ***
// Serial control logic of a current-output converter
// Function
// RL1: Shift serial input on each rising clock.
// RL2: Host keeps shift clock at most 30 MHz.
// RL3: Host holds serial input stable at rising edge.
// RL4: Strobe rise loads shift word into addressed register.
// RL5: Data register load updates output current.
// RL6: Serial output driven only in readback or chain.
// RL7: Serial output changes on falling shift clock.
// RL8: Zero-force input sets output to range zero-scale.
// RL9: Alarm pulled low on open loop or overtemperature.
// RL10: 24-bit word, MSB first, address then data.
// RL11: Decode NOP, data, readback, control, reset addresses.
// RL12: Host gives exactly 24 edges before strobe; the bench also sends one 32-edge frame.
// RL13: Shifting continues; latch last 24 bits.
// RL14: Serial output high impedance when idle.
// RL15: Zero-scale range taken from control register.
`timescale 1ns/10ps
`default_nettype none
module cdsc_top (
  input  wire logic        sys_clk_in,      // System clock, 40 MHz
  input  wire logic        reset_in,        // Asynchronous reset, active high
  input  wire logic        shift_clk_in,    // Link shift clock from host
  input  wire logic        serial_in,       // Serial data from host
  input  wire logic        load_strobe_in,  // Load strobe, rising edge acts
  input  wire logic        zero_force_in,   // Forces zero-scale while high
  input  wire logic        open_loop_in,    // Open output loop detected
  input  wire logic        over_temp_in,    // Overtemperature detected
  output logic             serial_out,      // Serial output data
  output logic             serial_oe_out,   // Serial output enable
  output logic             alarm_n_out,     // Open-drain alarm level, always 0
  output logic             alarm_oe_out,    // Alarm pull-down enable
  output logic [15:0]      dac_code_out,    // Code applied to current output
  output logic [2:0]       range_out,       // Programmed output range
  output logic             zero_scale_out,  // High when 4 mA zero-scale applies
  output logic             out_enable_out   // Output stage enabled
);
  // ---------------- Link domain (shift clock) ----------------
  logic [23:0] shift_r;        // Input shift register
  logic [23:0] shift_nxt;      // Next shift value
  logic [23:0] rd_shadow_r;    // Readback word for shifting out
  logic        rd_pend_tgl_r;  // Readback load toggle seen in link domain
  logic        rd_seen_r;      // Last toggle consumed
  logic        so_bit_r;       // Serial output bit, falling edge
  logic [23:0] rd_word_r;      // Readback word captured at strobe (sys domain)
  logic        rd_tgl_r;       // Toggle telling link domain a word waits
  logic        rd_tgl_m_r;     // Toggle sync stage one (link domain)
  logic        rd_tgl_s_r;     // Toggle sync stage two (link domain)
  logic        rd_load;        // Load shadow on this edge
  logic        rd_out_r;       // Readback shifting active (link domain)
  logic        chain_en_s;     // Daisy-chain enable in link domain

  assign shift_nxt = {shift_r[22:0], serial_in}; // MSB enters first, see RL10
  assign rd_load   = rd_tgl_s_r != rd_seen_r;

  // Shift serial input every rising edge, regardless of strobe
  always_ff @(posedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt; // see RL1 see RL13
    end
  end

  // Readback toggle synchroniser into link domain
  always_ff @(posedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_tgl_m_r <= 1'b0;
      rd_tgl_s_r <= 1'b0;
    end else begin
      rd_tgl_m_r <= rd_tgl_r;
      rd_tgl_s_r <= rd_tgl_m_r;
    end
  end

  // Readback shadow: load on new request, else shift left
  always_ff @(posedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_shadow_r <= '0;
      rd_seen_r   <= 1'b0;
      rd_pend_tgl_r <= 1'b0;
    end else if (rd_load) begin
      rd_shadow_r   <= rd_word_r;     // Stable word, held since strobe
      rd_seen_r     <= rd_tgl_s_r;
      rd_pend_tgl_r <= ~rd_pend_tgl_r;
    end else begin
      rd_shadow_r <= {rd_shadow_r[22:0], 1'b0};
    end
  end

  // Output bit updated on falling edge of shift clock
  always_ff @(negedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      so_bit_r <= 1'b0;
    end else begin
      so_bit_r <= chain_en_s ? shift_r[23] : rd_shadow_r[23]; // see RL7
    end
  end

  // ---------------- System domain ----------------
  logic        link_s;         // Synchronised strobe level
  logic        strobe_d_r;     // Strobe delayed for edge detect
  logic        strobe_rise;    // Strobe rising edge
  logic [23:0] word_cap_r;     // Word captured in link domain at strobe
  logic [15:0] data_r;         // Data register
  logic [15:0] ctrl_r;         // Control register
  logic        rd_act_r;       // Readback in progress
  logic [7:0]  addr_w;         // Address byte
  logic [15:0] dword_w;        // Data word
  logic        hit_data;       // Data register addressed
  logic        hit_ctrl;       // Control register addressed
  logic        hit_rdbk;       // Readback addressed
  logic        hit_rst;        // Reset register addressed
  logic [15:0] rd_val;         // Selected readback value
  logic        zf_s;           // Synchronised zero force
  logic        ol_s;           // Synchronised open loop
  logic        ot_s;           // Synchronised overtemperature
  logic [1:0]  stat_w;         // Status bits for readback
  logic        four_ma;        // 4 mA zero-scale range

  // Strobe captures shift word in link-facing flop on its own rise
  always_ff @(posedge load_strobe_in or posedge reset_in) begin
    if (reset_in) begin
      word_cap_r <= '0;
    end else begin
      word_cap_r <= shift_r; // Last 24 bits in, see RL13 see RL4
    end
  end

  // Strobe level and pins into system clock
  cdsc_sync #(.W(4)) u_sync (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .d_in     ({load_strobe_in, zero_force_in, open_loop_in, over_temp_in}),
    .q_out    ({link_s, zf_s, ol_s, ot_s})
  );

  assign strobe_rise = link_s & ~strobe_d_r;

  // Address decode, see RL11
  assign addr_w   = word_cap_r[cdsc_pkg::ADDR_MSB:cdsc_pkg::ADDR_LSB]; // see RL10
  assign dword_w  = word_cap_r[cdsc_pkg::DATA_W-1:0];
  assign hit_data = strobe_rise & (addr_w == cdsc_pkg::ADDR_DATA);
  assign hit_ctrl = strobe_rise & (addr_w == cdsc_pkg::ADDR_CTRL);
  assign hit_rdbk = strobe_rise & (addr_w == cdsc_pkg::ADDR_RDBK);
  assign hit_rst  = strobe_rise & (addr_w == cdsc_pkg::ADDR_RST) & dword_w[0];
  assign stat_w   = {ol_s, ot_s};
  assign rd_val   = (dword_w[1:0] == cdsc_pkg::RDSEL_DATA) ? data_r :
                    (dword_w[1:0] == cdsc_pkg::RDSEL_CTRL) ? ctrl_r :
                    {14'h0000, stat_w};
  assign four_ma  = ctrl_r[2:0] == cdsc_pkg::RANGE_4_20; // see RL15

  // Strobe edge detect register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= link_s;
    end
  end

  // Register writes and reset command
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      data_r <= cdsc_pkg::DATA_RST;
      ctrl_r <= cdsc_pkg::CTRL_RST;
    end else if (hit_rst) begin
      data_r <= cdsc_pkg::DATA_RST;
      ctrl_r <= cdsc_pkg::CTRL_RST;
    end else if (hit_data) begin
      data_r <= dword_w;          // see RL4
    end else if (hit_ctrl) begin
      ctrl_r <= dword_w;          // see RL4
    end
  end

  // Readback request: capture word, toggle to link domain
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_word_r <= '0;
      rd_tgl_r  <= 1'b0;
      rd_act_r  <= 1'b0;
    end else if (hit_rdbk) begin
      rd_word_r <= {cdsc_pkg::ADDR_NOP, rd_val};
      rd_tgl_r  <= ~rd_tgl_r;
      rd_act_r  <= 1'b1;
    end else if (strobe_rise) begin
      rd_act_r  <= 1'b0;          // Next strobe ends readback
    end
  end

  // Output mode and enable synchronised into link domain
  logic [1:0] oe_m_r;   // Sync stage one
  logic [1:0] oe_s_r;   // Sync stage two
  always_ff @(posedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oe_m_r <= '0;
      oe_s_r <= '0;
    end else begin
      oe_m_r <= {rd_act_r, ctrl_r[cdsc_pkg::DCHAIN_BIT]};
      oe_s_r <= oe_m_r;
    end
  end
  assign chain_en_s = oe_s_r[0];

  cdsc_pkg::cdsc_out_mode_t mode_r; // Serial output mode (link domain)
  // Output mode selection
  always_ff @(negedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_r <= cdsc_pkg::CDSC_OUT_IDLE;
    end else begin
      case ({oe_s_r[1], oe_s_r[0]})
        2'b10, 2'b11: mode_r <= cdsc_pkg::CDSC_OUT_RDBK;  // Readback wins
        2'b01:        mode_r <= cdsc_pkg::CDSC_OUT_CHAIN;
        default:      mode_r <= cdsc_pkg::CDSC_OUT_IDLE;
      endcase
    end
  end

  // Serial output pins from flops
  always_ff @(negedge shift_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_oe_out <= 1'b0;
      rd_out_r      <= 1'b0;
    end else begin
      serial_oe_out <= oe_s_r != 2'b00; // see RL6 see RL14
      rd_out_r      <= oe_s_r[1];
    end
  end
  assign serial_out = so_bit_r;

  // Output current code, range and alarm
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dac_code_out   <= cdsc_pkg::ZERO_CODE;
      range_out      <= 3'h0;
      zero_scale_out <= 1'b0;
      out_enable_out <= 1'b0;
      alarm_n_out    <= 1'b0;
      alarm_oe_out   <= 1'b0;
    end else begin
      dac_code_out   <= zf_s ? cdsc_pkg::ZERO_CODE : data_r; // see RL5 see RL8
      range_out      <= ctrl_r[2:0];                          // see RL15
      zero_scale_out <= four_ma;                              // see RL8
      out_enable_out <= ctrl_r[2];                            // Tracks range bit 2
      alarm_n_out    <= 1'b0;
      alarm_oe_out   <= ol_s | ot_s;                          // see RL9
    end
  end
endmodule
`default_nettype wire

// *** test/cdsc_top_chk.sv ***
// Concurrent checks on the ports of the serial control block
`timescale 1ns/10ps
`default_nettype none
module cdsc_top_chk (
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic        load_strobe_in,
  input wire logic        zero_force_in,
  input wire logic        open_loop_in,
  input wire logic        over_temp_in,
  input wire logic        alarm_n_out,
  input wire logic        alarm_oe_out,
  input wire logic [15:0] dac_code_out,
  input wire logic [2:0]  range_out,
  input wire logic        zero_scale_out,
  input wire logic        out_enable_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic       stb_q_r; // Strobe at last edge
  logic       zf_q_r;  // Zero force at last edge
  logic [3:0] quiet_r; // Edges since strobe rise or zero force change
  // Saturating count of quiet cycles; outputs may only move soon after a cause
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      stb_q_r <= 1'b0;
      zf_q_r  <= 1'b0;
      quiet_r <= 4'hf;
    end else begin
      stb_q_r <= load_strobe_in;
      zf_q_r  <= zero_force_in;
      if ((load_strobe_in && !stb_q_r) || (zero_force_in != zf_q_r)) begin
        quiet_r <= 4'h0;
      end else if (quiet_r != 4'hf) begin
        quiet_r <= quiet_r + 4'h1;
      end
    end
  end
  // Fault present, or absent, long enough to pass the synchroniser
  sequence s_fault_held;
    (open_loop_in || over_temp_in) [*5];
  endsequence
  sequence s_fault_gone;
    (!open_loop_in && !over_temp_in) [*5];
  endsequence
  a_alarm_set: assert property (s_fault_held |-> alarm_oe_out)
    else $error("alarm not pulled low");
  a_alarm_clr: assert property (s_fault_gone |-> !alarm_oe_out)
    else $error("alarm pulled without fault");
  a_alarm_level: assert property (!alarm_n_out)
    else $error("alarm level not low");
  a_zero_code: assert property (zero_force_in [*5] |-> dac_code_out == cdsc_pkg::ZERO_CODE)
    else $error("zero force ignored");
  a_zero_range: assert property (zero_scale_out == (range_out == cdsc_pkg::RANGE_4_20))
    else $error("zero scale flag wrong");
  a_out_enable: assert property (out_enable_out == range_out[2])
    else $error("output enable wrong");
  a_dac_quiet: assert property ($changed(dac_code_out) |-> quiet_r < 4'h8)
    else $error("code moved without cause");
  a_range_quiet: assert property ($changed(range_out) |-> quiet_r < 4'h8)
    else $error("range moved without cause");
endmodule
bind cdsc_top cdsc_top_chk chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .load_strobe_in(load_strobe_in),
  .zero_force_in(zero_force_in), .open_loop_in(open_loop_in), .over_temp_in(over_temp_in),
  .alarm_n_out(alarm_n_out), .alarm_oe_out(alarm_oe_out), .dac_code_out(dac_code_out),
  .range_out(range_out), .zero_scale_out(zero_scale_out), .out_enable_out(out_enable_out)
);
`default_nettype wire

// *** test/cdsc_host.sv ***
// Host model driving the three-wire serial link
`timescale 1ns/10ps
`default_nettype none
module cdsc_host (
  output logic      shift_clk_out,   // Link clock, still between frames
  output logic      serial_data_out, // Serial data to device
  output logic      strobe_out,      // Load strobe
  input  wire logic serial_back_in,  // Device serial return
  input  wire logic back_en_in       // Device return enable
);
  logic [23:0] cap_r;  // Last 24 returned bits
  int          oe_cnt; // Rising edges with return driven
  initial begin
    shift_clk_out   = 1'b0;
    serial_data_out = 1'b0;
    strobe_out      = 1'b0;
  end
  // Two clock pulses while reset is held
  task automatic pulse2;
    repeat (2) begin
      #17 shift_clk_out = 1'b1;
      #17 shift_clk_out = 1'b0;
    end
  endtask
  // Shift n bits MSB first at 34 ns period, then pulse the strobe
  task automatic send(input logic [31:0] w, input int n);
    oe_cnt = 0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_out = w[i];
      #17 shift_clk_out = 1'b1;
      cap_r  = {cap_r[22:0], serial_back_in};
      oe_cnt = oe_cnt + int'(back_en_in);
      #17 shift_clk_out = 1'b0;
    end
    serial_data_out = ~serial_data_out;   // Released line shows no stale bit
    #30 strobe_out = 1'b1;
    #120 strobe_out = 1'b0;
    #120;
  endtask
endmodule
`default_nettype wire

// *** test/cdsc_top_tb.sv ***
// Self-checking testbench for the converter serial control block
`timescale 1ns/10ps
`default_nettype none
module cdsc_top_tb;
  logic        sys_clk, reset, zero_force, open_loop, over_temp; // Bench-driven inputs
  logic        shift_clk, ser_data, strobe;                      // Host-driven link
  logic        ser_back, ser_oe, alarm_n, alarm_oe, out_en, zero_scale;
  logic [15:0] dac_code;      // Output current code
  logic [2:0]  range_val;     // Programmed range
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  cdsc_top dut (.sys_clk_in(sys_clk), .reset_in(reset), .shift_clk_in(shift_clk), .serial_in(ser_data),
    .load_strobe_in(strobe), .zero_force_in(zero_force), .open_loop_in(open_loop), .over_temp_in(over_temp),
    .serial_out(ser_back), .serial_oe_out(ser_oe), .alarm_n_out(alarm_n), .alarm_oe_out(alarm_oe),
    .dac_code_out(dac_code), .range_out(range_val), .zero_scale_out(zero_scale), .out_enable_out(out_en));
  cdsc_host host (.shift_clk_out(shift_clk), .serial_data_out(ser_data), .strobe_out(strobe),
    .serial_back_in(ser_back), .back_en_in(ser_oe));
  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.send({8'h00, a, d}, 24);
  endtask
  task automatic t_data;
    wr(cdsc_pkg::ADDR_DATA, 16'ha5c3);
    check("dac", dac_code, 24'ha5c3);
    host.send({8'hff, cdsc_pkg::ADDR_DATA, 16'h1234}, 32);
    check("dac last 24", dac_code, 24'h1234);
    wr(cdsc_pkg::ADDR_NOP, 16'hffff);
    check("dac nop", dac_code, 24'h1234);
    wr(8'h03, 16'hffff);
    check("dac unmapped", dac_code, 24'h1234);
    $display("test data done");
  endtask
  task automatic t_ctrl;
    logic [2:0] codes [3];
    codes = '{cdsc_pkg::RANGE_4_20, cdsc_pkg::RANGE_0_20, cdsc_pkg::RANGE_0_24};
    foreach (codes[i]) begin
      wr(cdsc_pkg::ADDR_CTRL, {13'h0000, codes[i]});
      check("range", range_val, codes[i]);
      check("zero scale", zero_scale, i == 0);
      check("out enable", out_en, codes[i][2]);
    end
    $display("test control done");
  endtask
  task automatic t_zero_alarm;
    wr(cdsc_pkg::ADDR_DATA, 16'h8000);
    @(negedge sys_clk);
    zero_force = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("forced code", dac_code, 24'h0000);
    zero_force = 1'b0;
    for (int v = 1; v < 5; v++) begin
      @(negedge sys_clk);
      {open_loop, over_temp} = v[1:0];
      repeat (6) @(negedge sys_clk);
      check("alarm enable", alarm_oe, v < 4);
      check("alarm level", alarm_n, 1'b0);
    end
    $display("test zero and alarm done");
  endtask
  task automatic t_return;
    wr(cdsc_pkg::ADDR_NOP, 16'h0000);
    check("idle drive", host.oe_cnt == 0, 1'b1);
    wr(cdsc_pkg::ADDR_RDBK, {14'h0000, cdsc_pkg::RDSEL_DATA});
    wr(cdsc_pkg::ADDR_NOP, 16'h0000);
    check("readback drive", host.oe_cnt > 20, 1'b1);
    wr(cdsc_pkg::ADDR_NOP, 16'h0000);
    check("readback end", host.oe_cnt <= 2, 1'b1);
    wr(cdsc_pkg::ADDR_CTRL, 16'h000f);
    host.send(32'h0000c35a, 24);
    host.send(32'h00000000, 24);
    check("chain data", host.cap_r, 24'h00c35a);
    check("chain drive", host.oe_cnt > 20, 1'b1);
    wr(cdsc_pkg::ADDR_RST, 16'h0001);
    check("reset command", {dac_code, range_val}, 24'h0);
    $display("test serial return done");
  endtask
  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    reset = 1'b1;
    zero_force = 1'b0;
    open_loop = 1'b0;
    over_temp = 1'b0;
    host.pulse2();
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("reset state", {dac_code, range_val, ser_oe, alarm_oe}, 24'h0);
    t_data();
    t_ctrl();
    t_zero_alarm();
    t_return();
    end_of_test();
  end
endmodule
`default_nettype wire
